// ==== rtl/ptp_map.svh ====
// constants of the processor trace port: field widths and exception kinds
`ifndef PTP_MAP_SVH
`define PTP_MAP_SVH
// Operation
// - a one-bit strobe marks a valid retired instruction on the port.
// - record fields mean something only while the strobe is high.
// - register-write flag with the 5-bit destination index beside it.
// - the 32-bit writeback value of the traced instruction is output.
// - exception-taken flag when the instruction really takes an exception; the code clears it when the exception kind is a reserved code.
// - 5-bit exception kind is valid only while exception-taken is high.
// - core fault kinds are codes 00000 through 00111.
// - interrupt 01010, non-maskable break 01011, maskable break 01100.
// - memory management kinds are codes 10000 through 10011.
// - unassigned exception kind codes are never emitted.
// - branch-taken flag when the branch condition is true.
// - delay-slot flag for an instruction in a taken branch's slot.
// - target-cache hit flag when the cache supplied the branch target.
// - area-optimized build leaves target hit and execute/memory advance meaningless.
// - valid data access flag with address, write value and byte enables.
// - data access direction shows as separate read and write flags.
// - data cache request when cacheable, hit when present in cache.
// - data cache done flag once a cacheable access completes.
// - data cache load flag is valid only while its request is high.
// - instruction cache request, hit and done flags.
// - decode, execute and memory stage advance indications.
// - halt flag while the pipeline is stopped by debug.
`define PTP_KIND_STREAM 5'h00
`define PTP_KIND_UNALIGN 5'h01
`define PTP_KIND_ILLEGAL 5'h02
`define PTP_KIND_IBUS 5'h03
`define PTP_KIND_DBUS 5'h04
`define PTP_KIND_DIVIDE 5'h05
`define PTP_KIND_FLOAT 5'h06
`define PTP_KIND_PRIV 5'h07
`define PTP_KIND_IRQ 5'h0a
`define PTP_KIND_NMBRK 5'h0b
`define PTP_KIND_MBRK 5'h0c
`define PTP_KIND_DSTORE 5'h10
`define PTP_KIND_ISTORE 5'h11
`define PTP_KIND_DTLB 5'h12
`define PTP_KIND_ITLB 5'h13
`define PTP_STATUS_W 15
`define PTP_PID_W 8
`endif

// ==== rtl/ptp_pkg.sv ====
// types of the processor trace port
package ptp_pkg;
  // arrays are [0:n] so that index 0 is the msb, as on the port
  typedef struct packed {
    logic [0:31] instrWord;
    logic [0:31] pc;
    logic regWrite;
    logic [0:4] regIndex;
    logic [0:14] statusWord;
    logic [0:7] processId;
    logic [0:31] newValue;
    logic excTaken;
    logic [0:4] excKind;
    logic branchTaken;
    logic targetHit;
    logic delaySlot;
    logic dataAccess;
    logic [0:31] dataAddr;
    logic [0:31] dataWrValue;
    logic [0:3] byteEnable;
    logic dataRead;
    logic dataWrite;
  } ptp_record_s;

  typedef struct packed {
    logic dcacheRequest;
    logic dcacheHit;
    logic dcacheDone;
    logic dcacheLoad;
    logic icacheRequest;
    logic icacheHit;
    logic icacheDone;
    logic decodeAdvance;
    logic executeAdvance;
    logic memoryAdvance;
    logic debugHalt;
  } ptp_pipe_s;

  typedef enum logic [1:0] {
    PTP_IDLE = 2'b00,
    PTP_SHOW = 2'b01
  } ptp_state_e;
endpackage

// ==== rtl/ptp_kind_check.sv ====
`timescale 1ns/1ps
// tells whether an exception kind code is one of the assigned encodings
module ptp_kind_check (
  input wire logic [0:4] kind,
  output logic legal
);
`include "ptp_map.svh"
  always_comb begin
    case (kind)
      `PTP_KIND_STREAM, `PTP_KIND_UNALIGN, `PTP_KIND_ILLEGAL, `PTP_KIND_IBUS,
      `PTP_KIND_DBUS, `PTP_KIND_DIVIDE, `PTP_KIND_FLOAT, `PTP_KIND_PRIV: begin
        legal = 1'b1;
      end
      `PTP_KIND_IRQ, `PTP_KIND_NMBRK, `PTP_KIND_MBRK: begin
        legal = 1'b1;
      end
      `PTP_KIND_DSTORE, `PTP_KIND_ISTORE, `PTP_KIND_DTLB, `PTP_KIND_ITLB: begin
        legal = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule

// ==== rtl/ptp_trace_port.sv ====
// Design decisions made here: dropping reserved exception kinds and forcing the area-optimized flags low.
`timescale 1ns/1ps
// trace output stage: registers the retirement record and pipeline flags
module ptp_trace_port #(
  parameter bit AREA_OPTIMIZED = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic retireValid,
  input wire ptp_pkg::ptp_record_s retireRecord,
  input wire ptp_pkg::ptp_pipe_s pipeState,
  output logic instrValid,
  output ptp_pkg::ptp_record_s traceRecord,
  output ptp_pkg::ptp_pipe_s tracePipe,
  output logic kindFault
);
`include "ptp_map.svh"

  typedef struct packed {
    ptp_pkg::ptp_state_e state;
    logic instrValid;
    ptp_pkg::ptp_record_s rec;
    ptp_pkg::ptp_pipe_s pipe;
    logic kindFault;
  } ptp_state_s;

  ptp_state_s st_r;
  ptp_state_s st_nxt;
  logic kindLegal;

  ptp_kind_check kindCheck (
    .kind(retireRecord.excKind),
    .legal(kindLegal)
  );

  always_comb begin
    st_nxt = st_r;
    // strobe lasts one cycle; a retirement each cycle gives back-to-back pulses
    st_nxt.instrValid = retireValid;
    st_nxt.state = retireValid ? ptp_pkg::PTP_SHOW : ptp_pkg::PTP_IDLE;
    st_nxt.kindFault = 1'b0;
    if (retireValid) begin
      st_nxt.rec = retireRecord;
      // write flag and index travel together
      st_nxt.rec.regWrite = retireRecord.regWrite;
      st_nxt.rec.regIndex = retireRecord.regIndex;
      st_nxt.rec.branchTaken = retireRecord.branchTaken;
      st_nxt.rec.delaySlot = retireRecord.delaySlot;
      st_nxt.rec.targetHit = AREA_OPTIMIZED ? 1'b0 : retireRecord.targetHit;
      st_nxt.rec.dataAccess = retireRecord.dataRead | retireRecord.dataWrite;
      st_nxt.rec.dataRead = retireRecord.dataRead;
      st_nxt.rec.dataWrite = retireRecord.dataWrite & ~retireRecord.dataRead;
      if (retireRecord.excTaken && !kindLegal) begin
        // a reserved code must never reach the port: drop the exception flag
        st_nxt.rec.excTaken = 1'b0;
        st_nxt.rec.excKind = 5'h00;
        st_nxt.kindFault = 1'b1;
      end else begin
        st_nxt.rec.excTaken = retireRecord.excTaken;
        // kind held at zero when no exception, which is harmless to observers
        st_nxt.rec.excKind = retireRecord.excTaken ? retireRecord.excKind : 5'h00;
      end
    end
    st_nxt.pipe = pipeState;
    // load direction is only meaningful with a request, so force it low otherwise
    st_nxt.pipe.dcacheLoad = pipeState.dcacheRequest & pipeState.dcacheLoad;
    if (AREA_OPTIMIZED) begin
      st_nxt.pipe.executeAdvance = 1'b0;
      st_nxt.pipe.memoryAdvance = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign instrValid = st_r.instrValid;
  assign traceRecord = st_r.rec;
  assign tracePipe = st_r.pipe;
  assign kindFault = st_r.kindFault;

  strobe_follows_a: assert property (@(posedge core_clk) disable iff (rst)
    retireValid |=> instrValid)
    else $error("strobe missing after retirement");

  strobe_single_a: assert property (@(posedge core_clk) disable iff (rst)
    !retireValid |=> !instrValid)
    else $error("strobe without retirement");

  record_pc_a: assert property (@(posedge core_clk) disable iff (rst)
    retireValid |=> traceRecord.pc == $past(retireRecord.pc))
    else $error("traced pc does not match retired pc");

  record_value_a: assert property (@(posedge core_clk) disable iff (rst)
    retireValid |=> traceRecord.newValue == $past(retireRecord.newValue))
    else $error("writeback value mismatch");

  reg_index_a: assert property (@(posedge core_clk) disable iff (rst)
    retireValid |=> traceRecord.regWrite == $past(retireRecord.regWrite)
      && traceRecord.regIndex == $past(retireRecord.regIndex))
    else $error("register write fields mismatch");

  kind_legal_a: assert property (@(posedge core_clk) disable iff (rst)
    instrValid && traceRecord.excTaken |-> traceRecord.excKind inside
      {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
       5'h0a, 5'h0b, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h13})
    else $error("reserved exception kind emitted");

  exc_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    retireValid && retireRecord.excTaken && retireRecord.excKind == 5'h0a
      |=> traceRecord.excTaken && traceRecord.excKind == 5'h0a)
    else $error("interrupt exception not traced");

  data_dir_a: assert property (@(posedge core_clk) disable iff (rst)
    instrValid |-> traceRecord.dataAccess == (traceRecord.dataRead | traceRecord.dataWrite)
      && !(traceRecord.dataRead && traceRecord.dataWrite))
    else $error("data access direction inconsistent");

  dload_qual_a: assert property (@(posedge core_clk) disable iff (rst)
    tracePipe.dcacheLoad |-> tracePipe.dcacheRequest)
    else $error("load flag without request");

  halt_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 tracePipe.debugHalt == $past(pipeState.debugHalt))
    else $error("halt flag not following pipeline");
endmodule

// ==== testbench/ptp_capture.sv ====
// trace capture model standing at the far side of the trace port
`timescale 1ns/1ps
module ptp_capture (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire ptp_pkg::ptp_record_s traceRecord,
  output ptp_pkg::ptp_record_s seenRecord,
  output int seenCount
);
  // plain capture only, no decoding of fields that may change meaning
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seenRecord <= '0;
      seenCount <= 0;
    end else if (instrValid) begin // fields ignored without the strobe
      seenRecord <= traceRecord;
      seenCount <= seenCount + 1;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the trace output stage
`timescale 1ns/1ps
module tb;
  logic core_clk;
  logic rst;
  logic retireValid;
  ptp_pkg::ptp_record_s retireRecord;
  ptp_pkg::ptp_pipe_s pipeState;
  logic instrValid;
  ptp_pkg::ptp_record_s traceRecord;
  ptp_pkg::ptp_pipe_s tracePipe;
  logic kindFault;
  ptp_pkg::ptp_record_s seenRecord;
  int seenCount;
  ptp_pkg::ptp_record_s areaRecord;
  ptp_pkg::ptp_pipe_s areaPipe;
  int err_total = 0;
  int checks_done = 0;
  ptp_trace_port i_dut (.core_clk(core_clk), .rst(rst), .retireValid(retireValid),
    .retireRecord(retireRecord), .pipeState(pipeState), .instrValid(instrValid),
    .traceRecord(traceRecord), .tracePipe(tracePipe), .kindFault(kindFault));
  ptp_capture i_cap (.core_clk(core_clk), .rst(rst), .instrValid(instrValid),
    .traceRecord(traceRecord), .seenRecord(seenRecord), .seenCount(seenCount));
  // second copy built area-optimized, so that the forced-low flags are exercised
  ptp_trace_port #(.AREA_OPTIMIZED(1'b1)) i_dutArea (.core_clk(core_clk), .rst(rst),
    .retireValid(retireValid), .retireRecord(retireRecord), .pipeState(pipeState),
    .instrValid(), .traceRecord(areaRecord), .tracePipe(areaPipe), .kindFault());
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chkVec(input logic [255:0] got, input logic [255:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s", $time, what);
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp, input string what);
    chkVec({255'h0, got}, {255'h0, exp}, what);
  endtask
  task automatic retire(input ptp_pkg::ptp_record_s r, input ptp_pkg::ptp_record_s e,
                        input logic fault);
    @(posedge core_clk);
    retireValid <= 1'b1;
    retireRecord <= r;
    @(posedge core_clk);
    retireValid <= 1'b0;
    #1;
    chkFlag(instrValid, 1'b1, "strobe missing");
    chkVec(traceRecord, e, "record wrong");
    chkFlag(kindFault, fault, "kind fault wrong");
  endtask
  task automatic scnData();
    ptp_pkg::ptp_record_s r;
    ptp_pkg::ptp_record_s e;
    r = '0;
    r.instrWord = 32'hdead_beef;
    r.pc = 32'h8000_0001;
    r.regWrite = 1'b1;
    r.regIndex = 5'h1f;
    r.statusWord = 15'h4001;
    r.processId = 8'ha5;
    r.newValue = 32'h1234_5678;
    r.excKind = 5'h0c;
    r.dataAddr = 32'hc000_0004;
    r.dataWrValue = 32'h0bad_f00d;
    r.byteEnable = 4'h9;
    r.dataRead = 1'b1;
    r.dataWrite = 1'b1;
    e = r;
    e.excKind = 5'h00;
    e.dataWrite = 1'b0;
    e.dataAccess = 1'b1;
    retire(r, e, 1'b0);
    chkFlag(traceRecord.pc[0], 1'b1, "pc msb not at index 0");
    @(posedge core_clk);
    #1;
    chkFlag(instrValid, 1'b0, "strobe longer than a cycle");
    chkVec(traceRecord, e, "record not held");
    chkVec(seenRecord, e, "capture record wrong");
    r.dataRead = 1'b0;
    e = r;
    e.excKind = 5'h00;
    e.dataAccess = 1'b1;
    retire(r, e, 1'b0);
  endtask
  task automatic scnBack();
    ptp_pkg::ptp_record_s r;
    r = '0;
    r.pc = 32'h0000_0010;
    @(posedge core_clk);
    retireValid <= 1'b1;
    retireRecord <= r;
    @(posedge core_clk);
    retireRecord.pc <= 32'h0000_0014;
    #1;
    chkVec(traceRecord.pc, 32'h0000_0010, "first of pair wrong");
    @(posedge core_clk);
    retireValid <= 1'b0;
    #1;
    chkFlag(instrValid, 1'b1, "second strobe missing");
    chkVec(traceRecord.pc, 32'h0000_0014, "second of pair wrong");
  endtask
  task automatic scnKinds();
    ptp_pkg::ptp_record_s r;
    ptp_pkg::ptp_record_s e;
    logic ok;
    for (int k = 0; k < 32; k++) begin
      r = '0;
      r.excTaken = 1'b1;
      r.excKind = k[4:0];
      r.branchTaken = k[0];
      r.delaySlot = k[1];
      r.targetHit = k[2];
      ok = (k < 8) || (k >= 10 && k <= 12) || (k >= 16 && k <= 19);
      e = r;
      if (!ok) begin
        e.excTaken = 1'b0;
        e.excKind = 5'h00;
      end
      retire(r, e, !ok);
      chkFlag(areaRecord.targetHit, 1'b0, "area build target hit set");
    end
  endtask
  task automatic scnPipe();
    logic [10:0] p;
    logic [10:0] e;
    for (int i = 0; i < 12; i++) begin
      p = (i == 11) ? 11'h480 : (11'h400 >> i);
      e = (i == 3) ? 11'h000 : p;
      @(posedge core_clk);
      pipeState <= p;
      @(posedge core_clk);
      pipeState <= '0;
      #1;
      chkVec(tracePipe, e, "pipe flags wrong");
      chkVec(areaPipe, e & ~11'h006, "area build pipe flags wrong");
    end
  endtask
  initial begin
    rst = 1'b1;
    retireValid = 1'b0;
    retireRecord = '0;
    pipeState = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chkFlag(instrValid, 1'b0, "strobe high after reset");
    chkVec(traceRecord, '0, "record not cleared");
    scnData();
    scnBack();
    scnKinds();
    scnPipe();
    chkVec(seenCount, 36, "capture count wrong");
    end_sim();
  end
endmodule
